// ### rtl/dft_consts.svh
// Constants of the dynamic fan start temperature loop: offsets, fields, resets, cycle counts.
// Assumes an 8-bit register address space reached over a plain strobe port.
`ifndef DFT_CONSTS_SVH
`define DFT_CONSTS_SVH

// Register offsets
`define DFT_OFS_OP_R1       8'h33
`define DFT_OFS_OP_LOC      8'h34
`define DFT_OFS_OP_R2       8'h35
`define DFT_OFS_CTRL1       8'h36
`define DFT_OFS_CTRL2       8'h37
`define DFT_OFS_LOW_R1      8'h4e
`define DFT_OFS_HIGH_R1     8'h4f
`define DFT_OFS_LOW_LOC     8'h50
`define DFT_OFS_HIGH_LOC    8'h51
`define DFT_OFS_LOW_R2      8'h52
`define DFT_OFS_HIGH_R2     8'h53
`define DFT_OFS_HYST_A      8'h6d
`define DFT_OFS_HYST_B      8'h6e
`define DFT_OFS_START_R1    8'h70
`define DFT_OFS_START_LOC   8'h71
`define DFT_OFS_START_R2    8'h72
`define DFT_OFS_FORMAT      8'h73

// Field positions in the first loop-control register
`define DFT_CTRL1_CYC_MSB   0
`define DFT_CTRL1_COPY_LSB  2
`define DFT_CTRL1_ADAPT_LSB 5
`define DFT_CTRL1_MASK      8'hfd

// Reset values
`define DFT_LOW_RST         8'h01
`define DFT_HIGH_RST        8'h7f
`define DFT_OP_RST          8'ha4
`define DFT_HYST_RST        4'h4
`define DFT_START_RST       8'h5a
`define DFT_CTRL_RST        8'h00

// Temperature arithmetic
`define DFT_OFS64_DEG       12'sh040
`define DFT_OFS64_QTR       12'sh100
`define DFT_FLOOR_TWOS      12'shf81
`define DFT_FLOOR_OFS64     12'shfc0
`define DFT_SMALL_RISE_QTR  12'sh001

// Short cycle length for code 000, in monitoring cycles
`define DFT_CYCLE_BASE      12'h008

`endif

// ### rtl/dft_pkg.sv
// Types shared by the dynamic fan start temperature loop.
// Assumes the constants header is included by each design file that needs numbers.
package dft_pkg;
    typedef logic [7:0]         dft_byte_t;   // Register byte
    typedef logic [9:0]         dft_temp_t;   // Measured temperature, 0.25 degree lsb
    typedef logic [2:0]         dft_code_t;   // Cycle selector code
    typedef logic signed [11:0] dft_sdeg_t;   // Signed degrees or quarter degrees
endpackage

// ### rtl/dft_cycle_timer.sv
// Monitoring-cycle counter of one channel, giving short and long cycle pulses.
// Assumes monitor_tick is a one-cycle pulse on clk, one per monitoring cycle.
`timescale 1ns/10ps
`include "dft_consts.svh"
module dft_cycle_timer import dft_pkg::*; (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      monitor_tick,
    input  wire logic      restart,
    input  wire dft_code_t code,
    output logic           short_tick,
    output logic           long_tick
);
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic [11:0] cnt_next;
    logic [11:0] short_len;
    logic [11:0] long_len;

    // Short length doubles with each code step; long is twice short
    assign short_len  = `DFT_CYCLE_BASE << code;
    assign long_len   = short_len << 1;
    assign cnt_next   = cnt_q + 12'h001;
    // A long cycle is always a short cycle too, even after the code shrinks mid-count
    assign short_tick = monitor_tick && !restart &&
                        (((cnt_next & (short_len - 12'h001)) == 12'h000) || (cnt_next >= long_len));
    assign long_tick  = monitor_tick && !restart && (cnt_next >= long_len);

    // Counter wraps at the long cycle and restarts when adaptation is enabled
    assign cnt_d = restart   ? 12'h000 :
                   long_tick ? 12'h000 :
                   monitor_tick ? cnt_next : cnt_q;

    // Counter register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 12'h000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_long_with_short: assert property (long_tick |-> short_tick)
        else $error("long cycle without short cycle");
    chk_restart_clears: assert property (restart |=> cnt_q == 12'h000)
        else $error("counter not restarted");
    chk_code0_short: assert property ((code == 3'h0) && short_tick && !long_tick |-> cnt_next == 12'h008)
        else $error("code 000 short cycle not at 8");
endmodule

// ### rtl/dft_chan_adjust.sv
// Fan start temperature adjustment of one channel for short and long cycles.
// Assumes temperatures and ticks come from logic on clk, in the selected format.
`timescale 1ns/10ps
`include "dft_consts.svh"
module dft_chan_adjust import dft_pkg::*; (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      adapt_en,
    input  wire logic      offset64,
    input  wire logic      monitor_tick,
    input  wire logic      short_tick,
    input  wire logic      long_tick,
    input  wire dft_temp_t temp_meas,
    input  wire dft_byte_t op_temp,
    input  wire logic [3:0] hyst,
    input  wire dft_byte_t low_lim,
    input  wire dft_byte_t high_lim,
    input  wire logic      sw_wr,
    input  wire dft_byte_t sw_data,
    output dft_byte_t      start_q
);
    // Register code to signed degrees
    function automatic dft_sdeg_t deg_of(input dft_byte_t v, input logic off64);
        deg_of = off64 ? ($signed({4'h0, v}) - `DFT_OFS64_DEG) : $signed({{4{v[7]}}, v});
    endfunction
    // Signed degrees to signed quarter degrees
    function automatic dft_sdeg_t qtr_of(input dft_sdeg_t d);
        qtr_of = $signed({d[9:0], 2'b00});
    endfunction
    // Measured code to signed quarter degrees
    function automatic dft_sdeg_t meas_of(input dft_temp_t t, input logic off64);
        meas_of = off64 ? ($signed({2'b00, t}) - `DFT_OFS64_QTR) : $signed({{2{t[9]}}, t});
    endfunction

    dft_temp_t prev_q;
    dft_byte_t start_d;
    dft_sdeg_t meas_qt, rise_qt, st_dg, op_dg, low_dg, hi_dg, floor_dg;
    dft_sdeg_t short_cut, long_cut, raise_dg, sum_dg, clamp_dg, enc_dg;
    logic      active, above_band, above_op, raise_ok, adj_go;

    // Operands in signed units
    assign meas_qt  = meas_of(temp_meas, offset64);
    assign rise_qt  = meas_qt - meas_of(prev_q, offset64);
    assign st_dg    = deg_of(start_q, offset64);
    assign op_dg    = deg_of(op_temp, offset64);
    assign low_dg   = deg_of(low_lim, offset64);
    assign hi_dg    = deg_of(high_lim, offset64);
    assign floor_dg = offset64 ? `DFT_FLOOR_OFS64 : `DFT_FLOOR_TWOS;

    // Loop acts only when enabled and at or above the start temperature
    assign active     = adapt_en && (meas_qt >= qtr_of(st_dg));
    assign above_band = meas_qt > qtr_of(op_dg - $signed({8'h00, hyst}));
    assign above_op   = meas_qt > qtr_of(op_dg);
    assign raise_ok   = (meas_qt < qtr_of(low_dg)) && (st_dg < hi_dg) &&
                        (st_dg < op_dg) && (meas_qt > qtr_of(st_dg));

    // Short cycle cuts twice the rise, which in quarters halved is degrees times two
    assign short_cut = (short_tick && active && above_band && (rise_qt > `DFT_SMALL_RISE_QTR)) ?
                       (rise_qt >>> 1) : 12'sh000;
    assign long_cut  = (long_tick && active && above_op) ? 12'sh001 : 12'sh000;
    assign raise_dg  = (long_tick && active && raise_ok) ? 12'sh001 : 12'sh000;

    // Combine, saturate and encode back to register format
    assign sum_dg   = st_dg - short_cut - long_cut + raise_dg;
    assign clamp_dg = ((raise_dg != 12'sh000) && (sum_dg > hi_dg)) ? hi_dg :
                      (sum_dg < floor_dg) ? floor_dg : sum_dg;
    assign enc_dg   = offset64 ? (clamp_dg + `DFT_OFS64_DEG) : clamp_dg;
    assign adj_go   = (short_cut != 12'sh000) || (long_cut != 12'sh000) || (raise_dg != 12'sh000);
    assign start_d  = sw_wr ? sw_data : adj_go ? enc_dg[7:0] : start_q;

    // Start temperature and previous measurement
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            start_q <= `DFT_START_RST;
            prev_q  <= 10'h000;
        end else begin
            start_q <= start_d;
            prev_q  <= monitor_tick ? temp_meas : prev_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_long_hot;
        long_tick && active && above_op && (short_cut == 12'sh000) && (raise_dg == 12'sh000) && !sw_wr &&
        (st_dg > floor_dg);
    endsequence

    chk_floor_clamp: assert property (adj_go && !sw_wr |=> st_dg >= $past(floor_dg))
        else $error("start temperature below floor");
    chk_high_sat: assert property ((raise_dg != 12'sh000) && !sw_wr |=> st_dg <= $past(hi_dg))
        else $error("start temperature above high limit");
    chk_hold_disabled: assert property (!adapt_en && !sw_wr |=> $stable(start_q))
        else $error("start temperature moved while disabled");
    chk_below_start: assert property ((meas_qt < qtr_of(st_dg)) && !sw_wr |=> $stable(start_q))
        else $error("adjusted below start temperature");
    chk_long_dec: assert property (s_long_hot |=> st_dg == $past(st_dg) - 12'sh001)
        else $error("long cycle did not lower by one");
    chk_mid_band: assert property (long_tick && !above_op && !raise_ok && (short_cut == 12'sh000) && !sw_wr
                                   |=> $stable(start_q))
        else $error("long cycle changed start in band");
    chk_small_rise: assert property (short_tick && !long_tick && (rise_qt <= 12'sh001) && !sw_wr
                                     |=> $stable(start_q))
        else $error("small rise reduced start temperature");
    chk_raise_one: assert property ((raise_dg != 12'sh000) && (short_cut == 12'sh000) && (long_cut == 12'sh000)
                                    && !sw_wr |=> st_dg == $past(st_dg) + 12'sh001)
        else $error("permitted raise not one degree");
endmodule

// ### rtl/dft_loop.sv
// Top of the dynamic fan start temperature loop: register file, alarm input and three channels.
// Assumes a plain strobe register port on clk, and temperatures plus monitor tick from logic on clk.
//
// Behaviour
// - Per-channel low/high limits, reset 0x01 and 0x7f.
// - Short cycle every n, long every 2n.
// - Per-channel three-bit cycle selector fields in control registers.
// - Code 000 gives 8/16; each step doubles.
// - Below band and above low limit: no change.
// - Above band, short cycle lowers by twice rise.
// - Rise of quarter degree or less: no cut.
// - Above operating point, long cycle lowers one degree.
// - Between band and operating point, long cycle idle.
// - Raise needs four conditions all true together.
// - Start temperature never raised above high limit.
// - Start floor is -127 or -64 by format.
// - Temperature below start temperature: no adjustment.
// - Alarm assertion copies temperature into operating point.
// - Per-channel copy enables in first control register.
// - Per-channel adaptive enables; clear keeps start fixed.
// - Hysteresis nibbles at 0x6d/0x6e, reset four degrees.
// - Operating points at 0x33..0x35, reset 0xa4.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "dft_consts.svh"
module dft_loop import dft_pkg::*; (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire dft_byte_t reg_addr,
    input  wire dft_byte_t reg_wdata,
    input  wire logic      reg_wr,
    input  wire logic      reg_rd,
    output dft_byte_t      reg_rdata,
    input  wire logic      monitor_tick,
    input  wire dft_temp_t temp_remote1,
    input  wire dft_temp_t temp_local,
    input  wire dft_temp_t temp_remote2,
    input  wire logic      thermal_alarm_n,
    output dft_byte_t      fan_start_remote1,
    output dft_byte_t      fan_start_local,
    output dft_byte_t      fan_start_remote2
);
    // Per-channel offsets, index 0 remote 1, 1 local, 2 remote 2
    localparam dft_byte_t LOW_OFS   [3] = '{`DFT_OFS_LOW_R1, `DFT_OFS_LOW_LOC, `DFT_OFS_LOW_R2};
    localparam dft_byte_t HIGH_OFS  [3] = '{`DFT_OFS_HIGH_R1, `DFT_OFS_HIGH_LOC, `DFT_OFS_HIGH_R2};
    localparam dft_byte_t OP_OFS    [3] = '{`DFT_OFS_OP_R1, `DFT_OFS_OP_LOC, `DFT_OFS_OP_R2};
    localparam dft_byte_t START_OFS [3] = '{`DFT_OFS_START_R1, `DFT_OFS_START_LOC, `DFT_OFS_START_R2};

    dft_byte_t   low_q   [3];
    dft_byte_t   high_q  [3];
    dft_byte_t   op_q    [3];
    dft_byte_t   op_d    [3];
    logic [3:0]  hyst_q  [3];
    dft_byte_t   start_w [3];
    dft_temp_t   temp_a  [3];
    dft_code_t   code_w  [3];
    dft_byte_t   ch_rd   [3];
    dft_byte_t   ctrl1_q;
    dft_byte_t   ctrl2_q;
    logic        fmt_q;
    logic [2:0]  adapt_prev_q;
    logic [2:0]  adapt_en;
    logic [2:0]  copy_en;
    logic [2:0]  restart;
    logic [2:0]  short_tick;
    logic [2:0]  long_tick;
    logic [2:0]  wr_op;
    logic        alm_meta_q;
    logic        alm_sync_q;
    logic        alm_prev_q;
    logic        alm_fall;
    dft_byte_t   glob_rd;
    dft_byte_t   rd_mux;

    // Channel inputs gathered for indexing
    assign temp_a[0] = temp_remote1;
    assign temp_a[1] = temp_local;
    assign temp_a[2] = temp_remote2;

    // Control field decode
    assign adapt_en  = ctrl1_q[`DFT_CTRL1_ADAPT_LSB +: 3];
    assign copy_en   = ctrl1_q[`DFT_CTRL1_COPY_LSB +: 3];
    assign code_w[0] = ctrl2_q[2:0];
    assign code_w[1] = ctrl2_q[5:3];
    assign code_w[2] = {ctrl1_q[`DFT_CTRL1_CYC_MSB], ctrl2_q[7:6]};
    assign restart   = adapt_en & ~adapt_prev_q;

    // Alarm pin synchroniser; only the second stage feeds the edge detect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alm_meta_q <= 1'b1;
            alm_sync_q <= 1'b1;
            alm_prev_q <= 1'b1;
        end else begin
            alm_meta_q <= thermal_alarm_n;
            alm_sync_q <= alm_meta_q;
            alm_prev_q <= alm_sync_q;
        end
    end

    // Falling edge of the synchronised alarm marks its assertion
    assign alm_fall = alm_prev_q && !alm_sync_q;

    // Global registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl1_q      <= `DFT_CTRL_RST;
            ctrl2_q      <= `DFT_CTRL_RST;
            fmt_q        <= 1'b0;
            adapt_prev_q <= 3'h0;
        end else begin
            ctrl1_q      <= (reg_wr && reg_addr == `DFT_OFS_CTRL1) ? (reg_wdata & `DFT_CTRL1_MASK) : ctrl1_q;
            ctrl2_q      <= (reg_wr && reg_addr == `DFT_OFS_CTRL2) ? reg_wdata : ctrl2_q;
            fmt_q        <= (reg_wr && reg_addr == `DFT_OFS_FORMAT) ? reg_wdata[0] : fmt_q;
            adapt_prev_q <= adapt_en;
        end
    end

    // Hysteresis nibbles; remote 1 high and local low of the first, remote 2 high of the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hyst_q[0] <= `DFT_HYST_RST;
            hyst_q[1] <= `DFT_HYST_RST;
            hyst_q[2] <= `DFT_HYST_RST;
        end else begin
            hyst_q[0] <= (reg_wr && reg_addr == `DFT_OFS_HYST_A) ? reg_wdata[7:4] : hyst_q[0];
            hyst_q[1] <= (reg_wr && reg_addr == `DFT_OFS_HYST_A) ? reg_wdata[3:0] : hyst_q[1];
            hyst_q[2] <= (reg_wr && reg_addr == `DFT_OFS_HYST_B) ? reg_wdata[7:4] : hyst_q[2];
        end
    end

    // Per-channel registers, cycle timer and adjustment
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_ch
            assign wr_op[i] = reg_wr && (reg_addr == OP_OFS[i]);
            // Software write wins over the alarm copy in the same cycle
            assign op_d[i]  = wr_op[i] ? reg_wdata :
                              (alm_fall && copy_en[i]) ? temp_a[i][9:2] : op_q[i];

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    low_q[i]  <= `DFT_LOW_RST;
                    high_q[i] <= `DFT_HIGH_RST;
                    op_q[i]   <= `DFT_OP_RST;
                end else begin
                    low_q[i]  <= (reg_wr && reg_addr == LOW_OFS[i]) ? reg_wdata : low_q[i];
                    high_q[i] <= (reg_wr && reg_addr == HIGH_OFS[i]) ? reg_wdata : high_q[i];
                    op_q[i]   <= op_d[i];
                end
            end

            dft_cycle_timer u_timer (
                .clk          (clk),
                .rst_n        (rst_n),
                .monitor_tick (monitor_tick),
                .restart      (restart[i]),
                .code         (code_w[i]),
                .short_tick   (short_tick[i]),
                .long_tick    (long_tick[i])
            );

            dft_chan_adjust u_adjust (
                .clk          (clk),
                .rst_n        (rst_n),
                .adapt_en     (adapt_en[i]),
                .offset64     (fmt_q),
                .monitor_tick (monitor_tick),
                .short_tick   (short_tick[i]),
                .long_tick    (long_tick[i]),
                .temp_meas    (temp_a[i]),
                .op_temp      (op_q[i]),
                .hyst         (hyst_q[i]),
                .low_lim      (low_q[i]),
                .high_lim     (high_q[i]),
                .sw_wr        (reg_wr && (reg_addr == START_OFS[i])),
                .sw_data      (reg_wdata),
                .start_q      (start_w[i])
            );

            // Channel read decode
            assign ch_rd[i] = (reg_addr == LOW_OFS[i])   ? low_q[i]   :
                              (reg_addr == HIGH_OFS[i])  ? high_q[i]  :
                              (reg_addr == OP_OFS[i])    ? op_q[i]    :
                              (reg_addr == START_OFS[i]) ? start_w[i] : 8'h00;
        end
    endgenerate

    // Global read decode; unmapped addresses read zero
    assign glob_rd = (reg_addr == `DFT_OFS_CTRL1)  ? ctrl1_q :
                     (reg_addr == `DFT_OFS_CTRL2)  ? ctrl2_q :
                     (reg_addr == `DFT_OFS_HYST_A) ? {hyst_q[0], hyst_q[1]} :
                     (reg_addr == `DFT_OFS_HYST_B) ? {hyst_q[2], 4'h0} :
                     (reg_addr == `DFT_OFS_FORMAT) ? {7'h00, fmt_q} : 8'h00;
    assign rd_mux  = glob_rd | ch_rd[0] | ch_rd[1] | ch_rd[2];

    // Read data stands for one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Start temperatures driven out from the channel registers
    assign fan_start_remote1 = start_w[0];
    assign fan_start_local   = start_w[1];
    assign fan_start_remote2 = start_w[2];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_alarm_copy(int ch);
        alm_fall && copy_en[ch] && !wr_op[ch];
    endsequence

    chk_limit_reset: assert property ($rose(rst_n) |-> low_q[1] == 8'h01 && high_q[2] == 8'h7f)
        else $error("limit reset values wrong");
    chk_op_reset: assert property ($rose(rst_n) |-> op_q[0] == 8'ha4 && op_q[2] == 8'ha4)
        else $error("operating point reset wrong");
    chk_hyst_reset: assert property ($rose(rst_n) |-> hyst_q[0] == 4'h4 && hyst_q[2] == 4'h4)
        else $error("hysteresis reset wrong");
    chk_alarm_copy: assert property (s_alarm_copy(1) |=> op_q[1] == $past(temp_local[9:2]))
        else $error("alarm did not copy temperature");
    chk_alarm_ignore: assert property (alm_fall && !copy_en[0] && !wr_op[0] |=> $stable(op_q[0]))
        else $error("alarm copied while disabled");
    chk_pin_delay: assert property ($fell(thermal_alarm_n) ##1 !thermal_alarm_n ##1 !thermal_alarm_n
                                    |-> alm_fall || !alm_prev_q)
        else $error("alarm edge not seen after sync");
    chk_read_hyst: assert property (reg_rd && reg_addr == `DFT_OFS_HYST_A && !reg_wr
                                    |=> reg_rdata == {hyst_q[0], hyst_q[1]})
        else $error("hysteresis readback wrong");
    chk_remote2_code: assert property (code_w[2][2] == ctrl1_q[0] && code_w[2][1:0] == ctrl2_q[7:6])
        else $error("remote 2 cycle code mapping wrong");
endmodule

// ### sim/dft_alarm_src.sv
// Model of the processor hot output that drives the active-low thermal alarm input.
// Assumes clk is the loop clock; the line has a pull-up and idles high when released.
`timescale 1ns/10ps
module dft_alarm_src (
    input  wire logic clk,
    output logic      alarm_n
);
    // Released line rests at the pull-up level
    initial alarm_n = 1'b1;

    // Pull low for n cycles, then release to the pulled-up level
    task automatic pull(input int n);
        alarm_n <= 1'b0;
        repeat (n) @(posedge clk);
        alarm_n <= 1'b1;
    endtask
endmodule

// ### sim/dynamic_fan_start_temp_loop_tb.sv
// Self-checking bench of the fan start temperature loop: registers, alarm copy, short/long cycles.
// Assumes the design's header and package are compiled first; a 10 MHz clock.
`timescale 1ns/10ps
`include "dft_consts.svh"
module dynamic_fan_start_temp_loop_tb import dft_pkg::*;;
    logic        clk, rst_n, reg_wr, reg_rd, monitor_tick, pend;
    dft_byte_t   reg_addr, reg_wdata, reg_rdata, fs1, fs2, fs3, exp_q[$];
    dft_temp_t   t1, t2, t3;
    wire logic   alarm_n;
    int          err_count, check_count;
    logic [31:0] seed;
    dft_byte_t   ra[15] = '{8'h4e, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h33, 8'h34, 8'h35,
                            8'h6d, 8'h6e, 8'h70, 8'h36, 8'h37, 8'h99};
    dft_byte_t   re[15] = '{8'h01, 8'h7f, 8'h01, 8'h7f, 8'h01, 8'h7f, 8'ha4, 8'ha4, 8'ha4,
                            8'h44, 8'h40, 8'h5a, 8'h00, 8'h00, 8'h00};

    dft_loop dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .monitor_tick(monitor_tick),
        .temp_remote1(t1), .temp_local(t2), .temp_remote2(t3), .thermal_alarm_n(alarm_n),
        .fan_start_remote1(fs1), .fan_start_local(fs2), .fan_start_remote2(fs3));
    dft_alarm_src src_u (.clk(clk), .alarm_n(alarm_n));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic cmp(input string nm, input dft_byte_t e, input dft_byte_t g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus cycle; every strobe is driven once per call so none is set twice in a step
    task automatic bus(input logic w, input logic r, input dft_byte_t a, input dft_byte_t d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    task automatic rd(input dft_byte_t a, input dft_byte_t e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            monitor_tick <= 1'b1;
            @(posedge clk);
            monitor_tick <= 1'b0;
            @(posedge clk);
        end
    endtask

    task automatic end_of_test;
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Read data stand only in the cycle after the strobe, so they are compared mid-cycle
    always @(posedge clk) pend <= reg_rd & rst_n;
    always @(negedge clk) if (pend) cmp("reg_rdata", exp_q.pop_front(), reg_rdata);

    // Watchdog, far beyond the hundred or so cycles of the sequence
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        end_of_test();
    end

    initial begin
        {rst_n, reg_wr, reg_rd, monitor_tick, reg_addr, reg_wdata} = '0;
        {t1, t2, t3} = '0;
        seed = 32'h1db64ac3;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, back-to-back reads, unmapped address last
        for (int i = 0; i < 15; i++) rd(ra[i], re[i]);
        seed = xs(seed);
        t2 <= seed[25:16];
        bus(1'b1, 1'b0, `DFT_OFS_LOW_R2, seed[7:0]);
        rd(`DFT_OFS_LOW_R2, seed[7:0]);
        bus(1'b1, 1'b0, `DFT_OFS_CTRL1, seed[15:8]);
        rd(`DFT_OFS_CTRL1, seed[15:8] & `DFT_CTRL1_MASK);
        bus(1'b1, 1'b0, `DFT_OFS_CTRL2, seed[31:24]);
        rd(`DFT_OFS_CTRL2, seed[31:24]);
        // Alarm copy enabled for remote 1 only
        bus(1'b1, 1'b0, `DFT_OFS_CTRL1, 8'h04);
        bus(1'b1, 1'b0, `DFT_OFS_CTRL2, 8'h00);
        t1 <= {8'h3c, 2'b01};
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        src_u.pull(5);
        repeat (6) @(posedge clk);
        rd(`DFT_OFS_OP_R1, 8'h3c);
        rd(`DFT_OFS_OP_LOC, 8'ha4);
        // Adaptive loop on remote 1, code 000, temperature above operating point
        bus(1'b1, 1'b0, `DFT_OFS_OP_R1, 8'h20);
        bus(1'b1, 1'b0, `DFT_OFS_START_R1, 8'h30);
        t1 <= {8'h40, 2'b00};
        bus(1'b1, 1'b0, `DFT_OFS_CTRL1, 8'h20);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        tick(15);
        cmp("fan_start_remote1", 8'h30, fs1);
        tick(1);
        cmp("fan_start_remote1", 8'h2f, fs1);
        tick(7);
        t1 <= {8'h41, 2'b00};
        tick(1);
        cmp("fan_start_remote1", 8'h2d, fs1);
        cmp("fan_start_local", `DFT_START_RST, fs2);
        cmp("fan_start_remote2", `DFT_START_RST, fs3);
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule
